// File: hw/rsbc_pkg.sv
// constants and types shared by the reset source and brown-out control block
package rsbc_pkg;

  localparam int CLK_PERIOD_NS          = 20;
  // filter duration for an under-voltage dip, nanoseconds
  localparam int BROWNOUT_FILTER_TIME_NS = 1000;
  // least time, rounded up, never below one cycle
  localparam int BROWNOUT_FILTER_CYCLES_RAW =
    (BROWNOUT_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BROWNOUT_FILTER_CYCLES =
    (BROWNOUT_FILTER_CYCLES_RAW < 1) ? 1 : BROWNOUT_FILTER_CYCLES_RAW;
  localparam int FILTER_CNT_W           = 8;
  localparam logic [FILTER_CNT_W-1:0] FILTER_CNT_MAX =
    FILTER_CNT_W'(BROWNOUT_FILTER_CYCLES);

  // core reset stretch after a one-cycle reset event
  localparam int PULSE_CNT_W            = 3;
  localparam logic [PULSE_CNT_W-1:0] RESET_PULSE_CYCLES = 3'h4;

  localparam int SYNC_WIDTH             = 4;

  localparam logic [1:0] MODE_ALWAYS_ON = 2'h3;
  localparam logic [1:0] MODE_SLEEP_OFF = 2'h2;
  localparam logic [1:0] MODE_SOFTWARE  = 2'h1;
  localparam logic [1:0] MODE_OFF       = 2'h0;

  localparam logic [8:0] FLAGS_RESET    = 9'h000;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_WAIT_READY,
    ST_RUN,
    ST_SLEEP
  } rsbc_state_e;

  // reset-cause flags, 1 = that cause was seen; the stack flags set even when no stack reset is enabled
  typedef struct packed {
    logic power_on;
    logic brownout_reset;
    logic reset_instruction_flag;
    logic ext_reset_pin_flag;
    logic watchdog_timeout_flag;
    logic watchdog_window_violation_flag;
    logic stack_underflow_flag;
    logic stack_overflow_flag;
    logic memory_violation_flag;
  } rsbc_flags_s;

  // one-cycle reset events from the core, synchronous to clk_i
  typedef struct packed {
    logic reset_instruction;
    logic watchdog_timeout;
    logic watchdog_window_violation;
    logic memory_violation;
    logic stack_overflow;
    logic stack_underflow;
  } rsbc_events_s;

endpackage : rsbc_pkg

// File: hw/rsbc_sync.sv
// two-flop synchroniser for asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module rsbc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule : rsbc_sync
`default_nettype wire

// File: hw/rsbc_top.sv
// reset source, brown-out mode and reset-cause flag control
`timescale 1ns/1ns
`default_nettype none
module rsbc_top (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  por_active_i,
  input  wire logic                  brownout_ready_i,
  input  wire logic                  brownout_low_i,
  input  wire logic                  external_reset_pin_n_i,
  input  wire logic [1:0]            brownout_mode_select_i,
  input  wire logic                  sw_brownout_enable_i,
  input  wire logic                  stack_reset_enable_i,
  input  wire logic                  sleep_i,
  input  wire rsbc_pkg::rsbc_events_s events_i,
  input  wire logic                  flag_wr_i,
  input  wire rsbc_pkg::rsbc_flags_s flag_wdata_i,
  output logic                       core_reset_o,
  output logic                       exec_enable_o,
  output logic                       brownout_detect_en_o,
  output logic                       brownout_ready_o,
  output var rsbc_pkg::rsbc_flags_s  flags_o
);
  import rsbc_pkg::*;

  logic [SYNC_WIDTH-1:0]   sync_q;
  logic                    s_por;
  logic                    s_ready;
  logic                    s_low;
  logic                    s_ext;
  logic                    detect_active;
  logic                    wait_needed;
  logic                    ready_ok;
  logic [FILTER_CNT_W-1:0] filter_cnt;
  logic                    brownout_trip;
  logic                    pulse_evt;
  logic [PULSE_CNT_W-1:0]  pulse_cnt;
  logic                    hold;
  logic [1:0]              settle;
  rsbc_state_e             state;
  rsbc_state_e             next_state;
  rsbc_flags_s             set_flags;

  rsbc_sync #(
    .WIDTH (SYNC_WIDTH)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({por_active_i, brownout_ready_i, brownout_low_i, ~external_reset_pin_n_i}),
    .sync_o  (sync_q)
  );

  assign s_por   = sync_q[3];
  assign s_ready = sync_q[2];
  assign s_low   = sync_q[1];
  assign s_ext   = sync_q[0];

  // detector enable per mode
  always_comb begin
    case (brownout_mode_select_i)
      MODE_ALWAYS_ON: detect_active = 1'b1;
      MODE_SLEEP_OFF: detect_active = (state != ST_SLEEP);
      MODE_SOFTWARE:  detect_active = sw_brownout_enable_i;
      default:        detect_active = 1'b0;
    endcase
  end

  // start and wake wait for the detector unless the mode is MODE_OFF or MODE_SOFTWARE with sw_brownout_enable_i low
  always_comb begin
    case (brownout_mode_select_i)
      MODE_ALWAYS_ON: wait_needed = 1'b1;
      MODE_SLEEP_OFF: wait_needed = 1'b1;
      MODE_SOFTWARE:  wait_needed = sw_brownout_enable_i;
      default:        wait_needed = 1'b0;
    endcase
  end

  assign ready_ok = s_ready &&
    (((brownout_mode_select_i == MODE_ALWAYS_ON) ||
      (brownout_mode_select_i == MODE_SLEEP_OFF)) ? !s_low : 1'b1);

  // under-voltage must persist beyond the filter time
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      filter_cnt <= '0;
    end else if (!detect_active || !s_ready || !s_low) begin
      filter_cnt <= '0;
    end else if (filter_cnt != FILTER_CNT_MAX) begin
      filter_cnt <= filter_cnt + 1'b1;
    end
  end

  assign brownout_trip = detect_active && s_ready && s_low &&
                         (filter_cnt == FILTER_CNT_MAX);

  assign pulse_evt = events_i.reset_instruction | events_i.watchdog_timeout |
                     events_i.watchdog_window_violation | events_i.memory_violation |
                     ((events_i.stack_overflow | events_i.stack_underflow) &
                      stack_reset_enable_i);

  // stretch one-cycle events into a short core reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_cnt <= '0;
    end else if (pulse_evt) begin
      pulse_cnt <= RESET_PULSE_CYCLES;
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - 1'b1;
    end
  end

  // keep the core held until the synchronisers carry real pin levels
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      settle <= 2'h0;
    end else begin
      settle <= {settle[0], 1'b1};
    end
  end

  assign hold = ~settle[1] | s_por | s_ext | brownout_trip | pulse_evt |
                (pulse_cnt != '0);

  always_comb begin
    next_state = state;
    case (state)
      ST_RESET: begin
        if (!hold) begin
          next_state = (wait_needed && !ready_ok) ? ST_WAIT_READY : ST_RUN;
        end
      end
      ST_WAIT_READY: begin
        if (hold) begin
          next_state = ST_RESET;
        end else if (!wait_needed || ready_ok) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (hold) begin
          next_state = ST_RESET;
        end else if (sleep_i) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (hold) begin
          next_state = ST_RESET;
        end else if (!sleep_i) begin
          next_state = (wait_needed && !ready_ok) ? ST_WAIT_READY : ST_RUN;
        end
      end
      default: next_state = ST_RESET;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      core_reset_o  <= 1'b1;
      exec_enable_o <= 1'b0;
    end else begin
      core_reset_o  <= hold;
      exec_enable_o <= (next_state == ST_RUN);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      brownout_detect_en_o <= 1'b0;
      brownout_ready_o     <= 1'b0;
    end else begin
      brownout_detect_en_o <= detect_active;
      brownout_ready_o     <= s_ready;
    end
  end

  always_comb begin
    set_flags                                = rsbc_flags_s'(FLAGS_RESET);
    set_flags.power_on                       = s_por;
    set_flags.brownout_reset                 = brownout_trip;
    set_flags.reset_instruction_flag         = events_i.reset_instruction;
    set_flags.ext_reset_pin_flag             = s_ext;
    set_flags.watchdog_timeout_flag          = events_i.watchdog_timeout;
    set_flags.watchdog_window_violation_flag = events_i.watchdog_window_violation;
    set_flags.stack_underflow_flag           = events_i.stack_underflow;
    set_flags.stack_overflow_flag            = events_i.stack_overflow;
    set_flags.memory_violation_flag          = events_i.memory_violation;
  end

  // hardware only sets; a set in the write cycle wins over the write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_o <= rsbc_flags_s'(FLAGS_RESET);
    end else begin
      flags_o <= rsbc_flags_s'((flag_wr_i ? flag_wdata_i : flags_o) | set_flags);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_stack_flag;
    events_i.stack_overflow |=> flags_o.stack_overflow_flag;
  endproperty
  a_stack_flag: assert property (p_stack_flag) else $error("overflow flag not set");

  property p_stack_reset;
    (events_i.stack_underflow && stack_reset_enable_i) |=> core_reset_o [*4];
  endproperty
  a_stack_reset: assert property (p_stack_reset) else $error("stack reset missing");

  property p_por_hold;
    por_active_i [*3] |=> core_reset_o && !exec_enable_o;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("core ran during power-on");

  property p_mode_detect;
    (brownout_mode_select_i == MODE_OFF) |=> !brownout_detect_en_o;
  endproperty
  a_mode_detect: assert property (p_mode_detect) else $error("detector on in mode 00");

  property p_start_ready;
    ($rose(exec_enable_o) && ((brownout_mode_select_i == MODE_ALWAYS_ON) ||
      (brownout_mode_select_i == MODE_SLEEP_OFF))) |-> $past(s_ready && !s_low);
  endproperty
  a_start_ready: assert property (p_start_ready) else $error("started before ready");

  property p_sleep_off;
    (brownout_mode_select_i == MODE_SLEEP_OFF && state == ST_SLEEP)
      |=> !brownout_detect_en_o;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("detector on in sleep");

  property p_sw_off_start;
    (brownout_mode_select_i == MODE_SOFTWARE && !sw_brownout_enable_i &&
     state == ST_RESET && !hold) |=> exec_enable_o;
  endproperty
  a_sw_off_start: assert property (p_sw_off_start) else $error("start delayed");

  property p_on_in_sleep;
    (brownout_mode_select_i == MODE_ALWAYS_ON && state == ST_SLEEP)
      |=> brownout_detect_en_o;
  endproperty
  a_on_in_sleep: assert property (p_on_in_sleep) else $error("protection off in sleep");

  property p_wake_no_delay;
    (brownout_mode_select_i == MODE_ALWAYS_ON && state == ST_SLEEP && !sleep_i && !hold &&
     s_ready && !s_low) |=> exec_enable_o;
  endproperty
  a_wake_no_delay: assert property (p_wake_no_delay) else $error("wake delayed");

  property p_filter;
    (!s_low ##1 s_low) |-> (!brownout_trip) [*8];
  endproperty
  a_filter: assert property (p_filter) else $error("short dip tripped");

  property p_only_cause;
    $rose(flags_o.watchdog_timeout_flag) |->
      $past(events_i.watchdog_timeout || (flag_wr_i && flag_wdata_i.watchdog_timeout_flag));
  endproperty
  a_only_cause: assert property (p_only_cause) else $error("wrong flag updated");

  property p_no_hw_clear;
    (($past(flags_o) & ~flags_o) != '0) |-> $past(flag_wr_i);
  endproperty
  a_no_hw_clear: assert property (p_no_hw_clear) else $error("flag cleared by hardware");

  property p_write_no_reset;
    (flag_wr_i && !hold) |=> !core_reset_o;
  endproperty
  a_write_no_reset: assert property (p_write_no_reset) else $error("write caused reset");

  property p_ready_status;
    brownout_ready_i [*3] |=> brownout_ready_o;
  endproperty
  a_ready_status: assert property (p_ready_status) else $error("ready status lags");

  c_brownout_trip: cover property (brownout_trip);
  c_wake_wait: cover property (state == ST_SLEEP ##1 state == ST_WAIT_READY);
  c_stack_reset: cover property (events_i.stack_overflow && stack_reset_enable_i);
  c_flag_clear: cover property (flag_wr_i && flags_o != rsbc_flags_s'(FLAGS_RESET));

endmodule : rsbc_top
`default_nettype wire

// File: tb/test_rsbc_top.sv
// self-checking bench for the reset source and brown-out control block
`timescale 1ns/1ns
`default_nettype none
module test_rsbc_top;
  import rsbc_pkg::*;
  logic clk, rst, por, rdy, low, ext_n, sw_en, stk_en, slp, wr;
  logic [1:0] mode;
  rsbc_events_s ev;
  rsbc_flags_s wd;
  rsbc_flags_s fl;
  logic core_rst, exec, det, bro;
  int fails;
  int checks_done;
  // flag bit raised by each event bit, lsb first
  localparam logic [8:0] EXP [6] = '{9'h004, 9'h002, 9'h001, 9'h008, 9'h010, 9'h040};

  rsbc_top dut (
    .clk_i(clk), .rst_i(rst), .por_active_i(por), .brownout_ready_i(rdy),
    .brownout_low_i(low), .external_reset_pin_n_i(ext_n),
    .brownout_mode_select_i(mode), .sw_brownout_enable_i(sw_en),
    .stack_reset_enable_i(stk_en), .sleep_i(slp), .events_i(ev),
    .flag_wr_i(wr), .flag_wdata_i(wd), .core_reset_o(core_rst),
    .exec_enable_o(exec), .brownout_detect_en_o(det),
    .brownout_ready_o(bro), .flags_o(fl)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task chk(input string name, input logic [8:0] e, input logic [8:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  task wflags(input logic [8:0] d);
    @(posedge clk) begin
      wr <= 1'b1;
      wd <= d;
    end
    @(posedge clk) wr <= 1'b0;
    #1;
    chk("flags_written", d, fl);
  endtask : wflags

  task wake(input logic [1:0] m, input logic sw, input logic r, input logic wt);
    @(posedge clk) begin
      mode <= m;
      sw_en <= sw;
      rdy <= r;
      slp <= 1'b1;
    end
    step(5);
    chk("exec_sleep", 9'h000, exec);
    chk("det_sleep", m == 2'h3 || (m == 2'h1 && sw), det);
    chk("ready_status", r, bro);
    @(posedge clk) slp <= 1'b0;
    step(3);
    chk("exec_wake", !wt, exec);
    @(posedge clk) rdy <= 1'b1;
    step(5);
    chk("exec_ready", 9'h001, exec);
    chk("det_awake", m[1] || (m == 2'h1 && sw), det);
    $display("test wake mode %0d done", m);
  endtask : wake

  initial begin
    #200000;
    fails++;
    complete_run();
  end

  initial begin
    int i;
    fails = 0;
    checks_done = 0;
    rst = 1'b1; por = 1'b0; rdy = 1'b1; low = 1'b0; ext_n = 1'b1;
    sw_en = 1'b0; stk_en = 1'b0; slp = 1'b0; wr = 1'b0; mode = 2'h3;
    ev = '0; wd = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    step(6);
    chk("core_reset_idle", 9'h000, core_rst);
    chk("exec_idle", 9'h001, exec);
    chk("flags_idle", 9'h000, fl);
    $display("test reset done");
    // power-on held, then released into an under-voltage supply
    @(posedge clk) begin
      por <= 1'b1;
      low <= 1'b1;
    end
    step(4);
    chk("core_reset_por", 9'h001, core_rst);
    chk("flags_por", 9'h100, fl);
    @(posedge clk) por <= 1'b0;
    step(1);
    chk("core_reset_sync", 9'h001, core_rst);
    step(5);
    chk("core_reset_rel", 9'h000, core_rst);
    chk("exec_low", 9'h000, exec);
    @(posedge clk) low <= 1'b0;
    step(5);
    chk("exec_high", 9'h001, exec);
    wflags(9'h000);
    @(posedge clk) ext_n <= 1'b0;
    step(4);
    chk("core_reset_pin", 9'h001, core_rst);
    chk("flags_pin", 9'h020, fl);
    @(posedge clk) ext_n <= 1'b1;
    step(5);
    chk("core_reset_pin_rel", 9'h000, core_rst);
    wflags(9'h000);
    $display("test power and pin done");
    // every event, stack ones without then with their reset enable
    for (i = 0; i < 8; i++) begin
      @(posedge clk) begin
        stk_en <= (i >= 6);
        ev <= rsbc_events_s'(6'h01 << (i % 6));
      end
      @(posedge clk) ev <= '0;
      #1;
      chk("flags_event", EXP[i % 6], fl);
      chk("core_reset_event", (i % 6) >= 2 || i >= 6, core_rst);
      step(4);
      chk("core_reset_hold", (i % 6) >= 2 || i >= 6, core_rst);
      step(1);
      chk("core_reset_end", 9'h000, core_rst);
      chk("flags_kept", EXP[i % 6], fl);
      wflags(9'h000);
    end
    $display("test events done");
    wflags(9'h1ff);
    step(4);
    chk("core_reset_swset", 9'h000, core_rst);
    wflags(9'h000);
    // an event in the same cycle as a clearing write keeps its flag
    @(posedge clk) begin
      wr <= 1'b1;
      wd <= 9'h000;
      ev <= rsbc_events_s'(6'h10);
    end
    @(posedge clk) begin
      wr <= 1'b0;
      ev <= '0;
    end
    #1;
    chk("flags_set_wins", 9'h010, fl);
    step(6);
    chk("core_reset_set_wins", 9'h000, core_rst);
    wflags(9'h000);
    $display("test software set done");
    // a dip shorter than the filter, then a long one
    @(posedge clk) low <= 1'b1;
    repeat (45) @(posedge clk);
    low <= 1'b0;
    step(6);
    chk("flags_short_dip", 9'h000, fl);
    chk("core_reset_short", 9'h000, core_rst);
    @(posedge clk) low <= 1'b1;
    step(56);
    chk("flags_long_dip", 9'h080, fl);
    chk("core_reset_long", 9'h001, core_rst);
    @(posedge clk) low <= 1'b0;
    step(12);
    chk("core_reset_after", 9'h000, core_rst);
    wflags(9'h000);
    @(posedge clk) mode <= 2'h0;
    @(posedge clk) low <= 1'b1;
    step(60);
    chk("flags_mode_off", 9'h000, fl);
    @(posedge clk) low <= 1'b0;
    $display("test filter done");
    wake(2'h3, 1'b0, 1'b1, 1'b0);
    wake(2'h2, 1'b0, 1'b0, 1'b1);
    wake(2'h1, 1'b1, 1'b0, 1'b1);
    wake(2'h1, 1'b0, 1'b0, 1'b0);
    wake(2'h0, 1'b0, 1'b0, 1'b0);
    complete_run();
  end
endmodule : test_rsbc_top
`default_nettype wire
